// [rtl/float_arith_map.svh]
// Purpose: Constants of the floating-point arithmetic and rounding unit
// Assumes: Single-precision word layout, sign / 8-bit exponent / fraction
// Notes:   Definitions only
`ifndef FLOAT_ARITH_MAP_SVH
`define FLOAT_ARITH_MAP_SVH

`define WORD_W        32
`define SIGN_BIT      31
`define EXP_MSB       30
`define EXP_LSB       23
`define FRAC_MSB      22
`define MANT_W        24
`define EXP_BIAS      10'sh07f
`define EXP_TOP       8'hff
`define EXP_OVF       10'sh0ff
`define I2F_EXP_BASE  10'sh09e
`define INT_TOP_EXP   10'sh01f
`define F2I_FRAC_SH   10'sh017
`define ALIGN_PAD     29
`define DIV_PAD       26
`define NAN_IEEE      32'h7fc00000
`define INF_IEEE      32'h7f800000
`define RSV_NATIVE    32'h80000000

`endif

// [rtl/float_arith_pkg.sv]
// Purpose: Types shared by the arithmetic unit and its neighbours
// Assumes: float_arith_map.svh supplies the widths
// Notes:   Field layouts only, no logic
`include "float_arith_map.svh"

package float_arith_pkg;

  typedef enum logic [2:0] {
    OP_ADD = 3'b000,
    OP_SUB = 3'b001,
    OP_MUL = 3'b010,
    OP_DIV = 3'b011,
    OP_F2I = 3'b100,
    OP_I2F = 3'b101
  } fop_t;

  typedef enum logic {
    MODE_NATIVE = 1'b0,
    MODE_IEEE   = 1'b1
  } fmode_t;

  typedef enum logic {
    DIV_RND_COMPAT   = 1'b0,
    DIV_RND_INDUSTRY = 1'b1
  } div_rnd_t;

  typedef struct packed {
    fop_t                 op;
    fmode_t               mode;
    div_rnd_t             div_rnd;
    logic [`WORD_W-1:0]   a;
    logic [`WORD_W-1:0]   b;
  } fop_req_t;

  typedef struct packed {
    logic input_exc;
    logic float_div_zero_flag;
    logic exp_ovf;
    logic exp_unf;
    logic int_ovf;
  } fflags_t;

  typedef struct packed {
    logic                 valid;
    logic [`WORD_W-1:0]   result;
    fflags_t              flags;
  } arith_state_t;

endpackage

// [rtl/round_inc.sv]
// Purpose: Decides the rounding increment from guard, round and sticky
// Assumes: Purely combinational, used inside the arithmetic unit
// Notes:   Divide ignores sticky in its table
`timescale 1ns/1ps

module round_inc (
  input  wire logic g,
  input  wire logic r,
  input  wire logic s,
  input  wire logic lsb,
  input  wire logic div_op,
  input  wire logic industry,
  output logic      inc
);

  // Divide: G=1,R=0 adds LSB or one; others: G=1,R=S=0 adds LSB
  assign inc = div_op ? (g & (r | industry | lsb))
                      : (g & (r | s | lsb));

endmodule

// [rtl/float_arith_unit.sv]
// Purpose: Floating add, subtract, multiply, divide and int conversions
// Assumes: Requests come from same-clock issue logic, one per cycle
// Notes:   Result and flags registered one edge after the request
//
// What this block does
// - Hidden one placed above stored fraction.
// - Guard then round bits below LSB.
// - Sticky is OR of bits below round.
// - Overflow bit above; V,G,R,S start zero.
// - Smaller-exponent fraction shifted right, sticky collects.
// - Zero operand has all fraction bits cleared.
// - Input exception skips alignment, gives output exception.
// - Exception classes differ by native or IEEE mode.
// - Zero sum gets zero exponent, no normalizing.
// - Overflow bit set: shift right, S=R|S.
// - Subtract: shift left, G takes R, S kept.
// - Add/sub/mul round table, ties to even.
// - Renormalize and adjust exponent after rounding carry.
// - Mul/div exceptions propagate; mul zero gives zero.
// - Multiply adds exponents with an extra bit.
// - Multiply keeps GRS, at most one left shift.
// - Zero divisor: exception and divide-zero flag.
// - Divide subtracts exponents, quotient n+2 bits.
// - Divide sticky is OR of remainder.
// - Divide round table, compatible or industry.
// - Float to integer truncates toward zero.
// - Integer to float normalizes, truncates excess bits.
// - Integer overflow returns low bits of result.
`timescale 1ns/1ps
`include "float_arith_map.svh"

module float_arith_unit
  import float_arith_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      req_valid,
  input  float_arith_pkg::fop_req_t      req,
  output logic                           res_valid,
  output logic [`WORD_W-1:0]             result,
  output float_arith_pkg::fflags_t       flags
);
  import float_arith_pkg::*;

  arith_state_t state_r;
  arith_state_t state_nxt;

  function automatic logic [5:0] lead_zeros(input logic [31:0] v);
    logic found;
    lead_zeros = 6'd0;
    found = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      if (!found) begin
        if (v[i]) found = 1'b1;
        else lead_zeros = lead_zeros + 6'd1;
      end
    end
  endfunction

  // Operand fields
  logic              sa, sb, za, zb, xa, xb;
  logic [7:0]        ea, eb;
  logic [`MANT_W-1:0] ma, mb;

  // Pre-round values shared by every arithmetic path
  logic              pre_sign, pre_g, pre_r, pre_s;
  logic [`MANT_W-1:0] pre_mant;
  logic signed [9:0] pre_exp;
  logic              use_round, is_zero;
  logic [`WORD_W-1:0] direct_val;
  fflags_t           pre_flags;

  // Add / subtract working signals
  logic              swap, eff_sub;
  logic [`MANT_W-1:0] big, sml;
  logic [7:0]        ebig, diff;
  logic [52:0]       aligned;
  logic [27:0]       xv, yv, sum, nv;
  logic [5:0]        lz;

  // Multiply, divide and conversion working signals
  logic [47:0]       prod;
  logic [49:0]       quo, rem, dvsr;
  logic signed [9:0] ue;
  logic [63:0]       mag64;
  logic [31:0]       imag, inorm;
  logic              inc;
  logic [`MANT_W:0]  rmant;

  always_comb begin
    sa = req.a[`SIGN_BIT];
    sb = req.b[`SIGN_BIT];
    ea = req.a[`EXP_MSB:`EXP_LSB];
    eb = req.b[`EXP_MSB:`EXP_LSB];
    if (req.mode == MODE_IEEE) begin
      xa = (ea == `EXP_TOP);
      xb = (eb == `EXP_TOP);
    end else begin
      xa = (ea == 8'h00) && sa;
      xb = (eb == 8'h00) && sb;
    end
    // Denormals count as zero; the unit has no gradual underflow
    za = (ea == 8'h00) && !xa;
    zb = (eb == 8'h00) && !xb;
    ma = za ? '0 : {1'b1, req.a[`FRAC_MSB:0]};
    mb = zb ? '0 : {1'b1, req.b[`FRAC_MSB:0]};
  end

  always_comb begin
    pre_sign   = 1'b0;
    pre_g      = 1'b0;
    pre_r      = 1'b0;
    pre_s      = 1'b0;
    pre_mant   = '0;
    pre_exp    = '0;
    use_round  = 1'b0;
    is_zero    = 1'b0;
    direct_val = '0;
    pre_flags  = '0;
    swap       = 1'b0;
    eff_sub    = 1'b0;
    big        = '0;
    sml        = '0;
    ebig       = '0;
    diff       = '0;
    aligned    = '0;
    xv         = '0;
    yv         = '0;
    sum        = '0;
    nv         = '0;
    lz         = '0;
    prod       = '0;
    quo        = '0;
    rem        = '0;
    dvsr       = 50'd1;
    ue         = '0;
    mag64      = '0;
    imag       = '0;
    inorm      = '0;
    case (req.op)
      OP_ADD, OP_SUB: begin
        if (xa || xb) begin
          pre_flags.input_exc = 1'b1;
          direct_val = (req.mode == MODE_IEEE) ? `NAN_IEEE : `RSV_NATIVE;
        end else begin
          swap = (eb > ea) || ((eb == ea) && (mb > ma));
          big  = swap ? mb : ma;
          sml  = swap ? ma : mb;
          ebig = swap ? eb : ea;
          diff = swap ? (eb - ea) : (ea - eb);
          // Pad wide enough that anything past R lands in the sticky field for diff up to 29
          aligned = {sml, {`ALIGN_PAD{1'b0}}} >> diff;
          eff_sub = sa ^ sb ^ (req.op == OP_SUB);
          xv = {1'b0, big, 2'b00, 1'b0};
          yv = {1'b0, aligned[52:27], |aligned[26:0]};
          sum = eff_sub ? (xv - yv) : (xv + yv);
          pre_sign = swap ? (sb ^ (req.op == OP_SUB)) : sa;
          if (sum == 28'd0) begin
            is_zero = 1'b1;
          end else if (sum[27]) begin
            nv = {1'b0, sum[27:1]};
            nv[0] = sum[1] | sum[0];
            pre_exp = $signed({2'b00, ebig}) + 10'sd1;
            use_round = 1'b1;
          end else begin
            // Zero fills from the right, sticky stays put
            lz = lead_zeros({sum[26:1], 6'b000000});
            nv = {1'b0, 26'(sum[26:1] << lz), sum[0]};
            pre_exp = $signed({2'b00, ebig}) - $signed({4'b0000, lz});
            use_round = 1'b1;
          end
          pre_mant = nv[26:3];
          pre_g    = nv[2];
          pre_r    = nv[1];
          pre_s    = nv[0];
        end
      end
      OP_MUL: begin
        pre_sign = sa ^ sb;
        if (xa || xb) begin
          pre_flags.input_exc = 1'b1;
          direct_val = (req.mode == MODE_IEEE) ? `NAN_IEEE : `RSV_NATIVE;
        end else if (za || zb) begin
          is_zero = 1'b1;
        end else begin
          // Ten bits hold sums past 255 until normalization settles
          pre_exp = $signed({2'b00, ea}) + $signed({2'b00, eb})
                    - `EXP_BIAS;
          prod = ma * mb;
          if (prod[47]) begin
            pre_exp  = pre_exp + 10'sd1;
            pre_mant = prod[47:24];
            pre_g    = prod[23];
            pre_r    = prod[22];
            pre_s    = |prod[21:0];
          end else begin
            pre_mant = prod[46:23];
            pre_g    = prod[22];
            pre_r    = prod[21];
            pre_s    = |prod[20:0];
          end
          use_round = 1'b1;
        end
      end
      OP_DIV: begin
        pre_sign = sa ^ sb;
        pre_flags.float_div_zero_flag = zb && !xb;
        if (xa || xb || zb) begin
          pre_flags.input_exc = xa || xb;
          direct_val = (req.mode == MODE_IEEE) ? `NAN_IEEE : `RSV_NATIVE;
        end else if (za) begin
          is_zero = 1'b1;
        end else begin
          pre_exp = $signed({2'b00, ea}) - $signed({2'b00, eb})
                    + `EXP_BIAS;
          dvsr = {26'd0, mb};
          quo  = {ma, {`DIV_PAD{1'b0}}} / dvsr;
          rem  = {ma, {`DIV_PAD{1'b0}}} % dvsr;
          if (quo[26]) begin
            pre_mant = quo[26:3];
            pre_g    = quo[2];
            pre_r    = quo[1];
            pre_s    = quo[0] | (rem != 50'd0);
          end else begin
            pre_exp  = pre_exp - 10'sd1;
            pre_mant = quo[25:2];
            pre_g    = quo[1];
            pre_r    = quo[0];
            pre_s    = (rem != 50'd0);
          end
          use_round = 1'b1;
        end
      end
      OP_F2I: begin
        ue = $signed({2'b00, ea}) - `EXP_BIAS;
        if (xa) begin
          pre_flags.input_exc = 1'b1;
          pre_flags.int_ovf   = 1'b1;
        end else if (!za && (ue >= 10'sd0)) begin
          // Fraction bits below the binary point are dropped
          if (ue >= `F2I_FRAC_SH)
            mag64 = {40'd0, ma} << (ue - `F2I_FRAC_SH);
          else
            mag64 = {40'd0, ma} >> (`F2I_FRAC_SH - ue);
          direct_val = sa ? (32'd0 - mag64[31:0]) : mag64[31:0];
          pre_flags.int_ovf = (ue > `INT_TOP_EXP) ||
            ((ue == `INT_TOP_EXP) &&
             !(sa && (req.a[`FRAC_MSB:0] == 23'd0)));
        end
      end
      OP_I2F: begin
        pre_sign = req.a[`SIGN_BIT];
        imag = pre_sign ? (32'd0 - req.a) : req.a;
        if (imag == 32'd0) begin
          is_zero = 1'b1;
        end else begin
          lz = lead_zeros(imag);
          inorm = imag << lz;
          // Excess low bits are truncated, guard stays zero
          pre_mant = inorm[31:8];
          pre_exp = `I2F_EXP_BASE - $signed({4'b0000, lz});
          use_round = 1'b1;
        end
      end
      default: begin
        direct_val = '0;
      end
    endcase
  end

  round_inc u_round_inc (
    .g        (pre_g),
    .r        (pre_r),
    .s        (pre_s),
    .lsb      (pre_mant[0]),
    .div_op   (req.op == OP_DIV),
    .industry (req.div_rnd == DIV_RND_INDUSTRY),
    .inc      (inc)
  );

  logic signed [9:0] fin_exp;
  logic [`MANT_W-1:0] fin_mant;

  always_comb begin
    rmant    = {1'b0, pre_mant} + {{`MANT_W{1'b0}}, inc};
    fin_mant = pre_mant;
    fin_exp  = pre_exp;
    if (rmant[`MANT_W]) begin
      fin_mant = rmant[`MANT_W:1];
      fin_exp  = pre_exp + 10'sd1;
    end else begin
      fin_mant = rmant[`MANT_W-1:0];
    end
    state_nxt       = state_r;
    state_nxt.valid = req_valid;
    if (req_valid) begin
      state_nxt.flags = pre_flags;
      if (is_zero) begin
        state_nxt.result = '0;
      end else if (!use_round) begin
        state_nxt.result = direct_val;
      end else if (fin_exp >= `EXP_OVF) begin
        state_nxt.flags.exp_ovf = 1'b1;
        state_nxt.result = (req.mode == MODE_IEEE)
          ? (`INF_IEEE | {pre_sign, 31'd0}) : `RSV_NATIVE;
      end else if (fin_exp <= 10'sd0) begin
        // No denormal results; small values flush to zero
        state_nxt.flags.exp_unf = 1'b1;
        state_nxt.result = '0;
      end else begin
        state_nxt.result = {pre_sign, fin_exp[7:0],
                            fin_mant[`FRAC_MSB:0]};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) state_r <= '0;
    else state_r <= state_nxt;
  end

  assign res_valid = state_r.valid;
  assign result    = state_r.result;
  assign flags     = state_r.flags;

endmodule

// [verif/float_arith_monitor.sv]
// Purpose: Port-level checks of the arithmetic unit
// Assumes: Only top ports visible, one clock domain
// Notes:   Bound into every unit instance
`timescale 1ns/1ps
`include "float_arith_map.svh"

module float_arith_monitor
  import float_arith_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 rst,
  input wire logic                 req_valid,
  input float_arith_pkg::fop_req_t req,
  input wire logic                 res_valid,
  input wire logic [`WORD_W-1:0]   result,
  input float_arith_pkg::fflags_t  flags
);
  import float_arith_pkg::*;

  logic [7:0] ea;
  logic [7:0] eb;
  logic       ieee;
  logic       arith;
  assign ea    = req.a[30:23];
  assign eb    = req.b[30:23];
  assign ieee  = req_valid && req.mode == MODE_IEEE;
  assign arith = req.op inside {OP_ADD, OP_SUB, OP_MUL, OP_DIV};

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  chk_answer_next: assert property (req_valid |=> res_valid)
    else $error("no answer one edge after request");
  chk_no_extra: assert property (!req_valid |=> !res_valid)
    else $error("answer without request");
  // Result must not drift between requests
  chk_result_hold: assert property
    (!req_valid |=> $stable(result) && $stable(flags))
    else $error("result changed without request");
  chk_ieee_exc: assert property (
    ieee && arith && ea == 8'hff
    |=> result == 32'h7fc00000 && flags.input_exc)
    else $error("ieee exception not propagated");
  chk_native_exc: assert property (
    req_valid && req.mode == MODE_NATIVE && arith && req.a[31] && ea == 8'h00
    |=> result == 32'h80000000 && flags.input_exc)
    else $error("reserved operand not propagated");
  chk_div_zero: assert property (
    ieee && req.op == OP_DIV && ea != 8'h00 && ea != 8'hff && eb == 8'h00
    |=> flags.float_div_zero_flag && result == 32'h7fc00000)
    else $error("divide by zero not flagged");
  chk_dz_div_only: assert property (
    req_valid && req.op != OP_DIV |=> !flags.float_div_zero_flag)
    else $error("divide zero flag outside divide");
  chk_mul_zero: assert property (
    ieee && req.op == OP_MUL && ea == 8'h00 && eb != 8'hff
    |=> result == 32'h00000000)
    else $error("multiply by zero not zero");
  chk_sub_same: assert property (
    ieee && req.op == OP_SUB && req.a == req.b && ea != 8'h00 && ea != 8'hff
    |=> result == 32'h00000000 && flags == 5'h00)
    else $error("self subtract not zero");
  chk_f2i_frac: assert property (
    req_valid && req.op == OP_F2I && ea inside {[8'h01:8'h7e]}
    |=> result == 32'h00000000)
    else $error("fraction not truncated to zero");
  chk_i2f_zero: assert property (
    req_valid && req.op == OP_I2F && req.a == 32'h00000000
    |=> result == 32'h00000000)
    else $error("integer zero not zero");
endmodule

bind float_arith_unit float_arith_monitor u_mon (
  .clk       (clk),
  .rst       (rst),
  .req_valid (req_valid),
  .req       (req),
  .res_valid (res_valid),
  .result    (result),
  .flags     (flags)
);

// [verif/issue_model.sv]
// Purpose: Issue logic model, one request at a time
// Assumes: Same clock as the unit
// Notes:   Released lines show the inverse of the last request
`timescale 1ns/1ps

module issue_model
  import float_arith_pkg::*;
(
  input  wire logic                clk,
  output logic                     req_valid,
  output float_arith_pkg::fop_req_t req
);
  import float_arith_pkg::*;

  initial begin
    req_valid = 1'b0;
    req       = '0;
  end

  // Mode and divide rounding travel with every request
  task automatic issue(input fop_req_t r);
    @(posedge clk);
    req_valid <= 1'b1;
    req       <= r;
    @(posedge clk);
    req_valid <= 1'b0;
    req       <= ~r;
  endtask
endmodule

// [verif/test_float_arith_unit.sv]
// Purpose: Directed checks of the arithmetic unit
// Assumes: Expected values worked by hand in single precision
// Notes:   md holds {mode, divide rounding} for the next requests
`timescale 1ns/1ps

module test_float_arith_unit;
  import float_arith_pkg::*;

  logic        clk;
  logic        rst;
  logic        req_valid;
  fop_req_t    req;
  logic        res_valid;
  logic [31:0] result;
  fflags_t     flags;
  logic [1:0]  md;
  int          fail_count;
  int          checks;

  initial clk = 1'b0;
  always #4 clk = ~clk;

  issue_model u_issue (
    .clk       (clk),
    .req_valid (req_valid),
    .req       (req)
  );

  float_arith_unit DUT (
    .clk       (clk),
    .rst       (rst),
    .req_valid (req_valid),
    .req       (req),
    .res_valid (res_valid),
    .result    (result),
    .flags     (flags)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Answer lands on the same edge that takes the request, so look at mid-cycle
  task automatic ex(input fop_t op, input logic [31:0] a, b, er,
                    input logic [4:0] ef);
    fop_req_t r;
    r = '{op, fmode_t'(md[1]), div_rnd_t'(md[0]), a, b};
    u_issue.issue(r);
    @(negedge clk);
    check({31'h0, res_valid}, 32'h1);
    check(result, er);
    check({27'h0, flags}, {27'h0, ef});
  endtask

  initial begin
    fail_count = 0;
    checks     = 0;
    md         = 2'h2;
    rst        = 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check({31'h0, res_valid}, 32'h0);
    check(result, 32'h0);
    $display("test reset done");
    ex(OP_ADD, 32'h3f800000, 32'h3f800000, 32'h40000000, 5'h00);
    ex(OP_ADD, 32'h3f800000, 32'h33800000, 32'h3f800000, 5'h00);
    ex(OP_ADD, 32'h3f800001, 32'h33800000, 32'h3f800002, 5'h00);
    ex(OP_ADD, 32'h3f800000, 32'h33800001, 32'h3f800001, 5'h00);
    ex(OP_ADD, 32'h3fffffff, 32'h33800000, 32'h40000000, 5'h00);
    ex(OP_ADD, 32'h00000000, 32'h3f800000, 32'h3f800000, 5'h00);
    ex(OP_SUB, 32'h3f800000, 32'h3f800000, 32'h00000000, 5'h00);
    ex(OP_SUB, 32'h40000000, 32'h3f800000, 32'h3f800000, 5'h00);
    ex(OP_SUB, 32'h3f800000, 32'h33000000, 32'h3f800000, 5'h00);
    ex(OP_ADD, 32'h7fc00000, 32'h3f800000, 32'h7fc00000, 5'h10);
    $display("test add_sub done");
    ex(OP_MUL, 32'h3fc00000, 32'h3fc00000, 32'h40100000, 5'h00);
    ex(OP_MUL, 32'h3f800800, 32'h3f800800, 32'h3f801000, 5'h00);
    ex(OP_MUL, 32'h00000000, 32'h3f800000, 32'h00000000, 5'h00);
    ex(OP_MUL, 32'h7f800000, 32'h3f800000, 32'h7fc00000, 5'h10);
    ex(OP_MUL, 32'h7f000000, 32'h7f000000, 32'h7f800000, 5'h04);
    ex(OP_MUL, 32'h00800000, 32'h00800000, 32'h00000000, 5'h02);
    md = 2'h0;
    ex(OP_ADD, 32'h80000000, 32'h3f800000, 32'h80000000, 5'h10);
    ex(OP_MUL, 32'h80000000, 32'h3f800000, 32'h80000000, 5'h10);
    ex(OP_DIV, 32'h3f800000, 32'h00000000, 32'h80000000, 5'h08);
    md = 2'h2;
    $display("test mul done");
    ex(OP_DIV, 32'h3f800000, 32'h00000000, 32'h7fc00000, 5'h08);
    ex(OP_DIV, 32'h7fc00000, 32'h3f800000, 32'h7fc00000, 5'h10);
    ex(OP_DIV, 32'h00000000, 32'h3f800000, 32'h00000000, 5'h00);
    ex(OP_DIV, 32'h40400000, 32'h3f800000, 32'h40400000, 5'h00);
    ex(OP_DIV, 32'h3f800000, 32'h40400000, 32'h3eaaaaaa, 5'h00);
    ex(OP_DIV, 32'h3f800000, 32'h40a00000, 32'h3e4ccccd, 5'h00);
    md = 2'h3;
    ex(OP_DIV, 32'h3f800000, 32'h40400000, 32'h3eaaaaab, 5'h00);
    ex(OP_DIV, 32'h3f800000, 32'h40a00000, 32'h3e4ccccd, 5'h00);
    md = 2'h2;
    $display("test div done");
    ex(OP_F2I, 32'h40600000, 32'h00000000, 32'h00000003, 5'h00);
    ex(OP_F2I, 32'hc0600000, 32'h00000000, 32'hfffffffd, 5'h00);
    ex(OP_F2I, 32'h3f000000, 32'h00000000, 32'h00000000, 5'h00);
    ex(OP_F2I, 32'h4f800000, 32'h00000000, 32'h00000000, 5'h01);
    ex(OP_F2I, 32'h4f000001, 32'h00000000, 32'h80000100, 5'h01);
    ex(OP_F2I, 32'h7f800000, 32'h00000000, 32'h00000000, 5'h11);
    ex(OP_I2F, 32'h00000003, 32'h00000000, 32'h40400000, 5'h00);
    ex(OP_I2F, 32'h01000003, 32'h00000000, 32'h4b800001, 5'h00);
    ex(OP_I2F, 32'hffffffff, 32'h00000000, 32'hbf800000, 5'h00);
    ex(OP_I2F, 32'h00000000, 32'h00000000, 32'h00000000, 5'h00);
    // Undefined opcode must give a clean zero, not stale data
    ex(fop_t'(3'h6), 32'h3f800000, 32'h3f800000, 32'h0, 5'h00);
    $display("test conv done");
    give_verdict();
  end

  // About 96 cycles expected; generous margin
  initial begin
    repeat (2000) @(posedge clk);
    fail_count++;
    give_verdict();
  end
endmodule
